// File: include/wfg_pkg.sv
package wfg_pkg;
    // buffer geometry
    localparam int BUF_DEPTH = 2048;
    localparam int ADDR_W = 11;
    localparam int SAMPLE_W = 16;
    localparam int NUM_CH = 2;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_FRAMES = 8'h08;
    localparam logic [7:0] OFS_DIV = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_BUF_ADDR = 8'h14;
    localparam logic [7:0] OFS_BUF_DATA = 8'h18;
    localparam logic [7:0] OFS_BULK = 8'h1C;

    // control field positions
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_CONT_BIT = 2;
    localparam int CTRL_CH1_BIT = 3;

    // command bits
    localparam int CMD_START_BIT = 0;
    localparam int CMD_PAUSE_BIT = 1;
    localparam int CMD_RESET_BIT = 2;
    localparam int CMD_INC_BIT = 3;
    localparam int CMD_CONFIG_BIT = 4;

    // reset values
    localparam logic [31:0] DIV_RESET = 32'h0000_00FA;
    localparam logic [11:0] FRAMES_RESET = 12'h001;

    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // clock sources
    typedef enum logic [1:0] {
        SRC_SOFT = 2'b00,
        SRC_EXT = 2'b01,
        SRC_CNT0 = 2'b10,
        SRC_CNT1 = 2'b11
    } wfg_src_t;

    // engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_PAUSE = 2'b10,
        ST_DONE = 2'b11
    } wfg_state_t;

    // one sample handed to the converter
    typedef struct packed {
        logic [SAMPLE_W-1:0] code;
        logic chan;
    } wfg_sample_t;
endpackage

// File: logic/wfg_engine.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - buffer holds unsigned 16-bit codes, passed unchanged to the channel
// - multi-channel data interleaved, one sample per channel per frame
// - 2048 samples total; read address never passes the last entry
// - bulk port stores successive words from address zero upward
// - single-entry write any time, playback untouched
// - config picks source, internal rate, one-shot or continuous
// - one-shot plays every frame once then stops itself
// - continuous wraps to first frame until software stops it
// - running engine advances on events from chosen source; counter 0 and 1 also take the internal rate tick
// - pause freezes position; start resumes from there
// - reset command stops engine, clears position, keeps buffer
// - software increment outputs exactly one frame per request
// - two channels, 0 and 1, may play together
// - sources: software, external line, counter 0, counter 1
module wfg_engine (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // axi4-lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // axi4-lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // clock sources from outside
    input wire logic i_ext_clk,
    input wire logic i_cnt0_clk,
    input wire logic i_cnt1_clk,
    // converter side
    output wfg_pkg::wfg_sample_t o_dac,
    output logic o_dac_valid
);
    import wfg_pkg::*;

    function automatic logic is_rise(input logic [2:0] s);
        return s[1] && !s[2];
    endfunction

    logic [SAMPLE_W-1:0] mem [0:BUF_DEPTH-1];
    logic [1:0] src_ff;
    logic cont_ff, dual_ff, configured_ff;
    logic [11:0] frames_ff;
    logic [31:0] div_ff, divcnt_ff;
    logic [ADDR_W-1:0] bufaddr_ff, bulk_ff, rptr_ff;
    logic [10:0] frame_idx_ff;
    wfg_state_t state_ff;
    logic [2:0] ext_ff, c0_ff, c1_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic sec_ff, emit_ff, emit_ch_ff;
    logic [ADDR_W-1:0] emit_addr_ff;

    // pin synchronisers, rising edge seen when second stage is high and third stage low
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_ff <= 3'h0;
            c0_ff <= 3'h0;
            c1_ff <= 3'h0;
        end else begin
            ext_ff <= {ext_ff[1:0], i_ext_clk};
            c0_ff <= {c0_ff[1:0], i_cnt0_clk};
            c1_ff <= {c1_ff[1:0], i_cnt1_clk};
        end
    end

    // write channel capture, address and data in either order
    logic wr_go;
    assign wr_go = aw_ff && w_ff && !o_bvalid;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_ff <= 1'b1;
                awaddr_ff <= i_awaddr;
            end else if (wr_go) begin
                aw_ff <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_ff <= 1'b1;
                wdata_ff <= i_wdata;
                wstrb_ff <= i_wstrb;
            end else if (wr_go) begin
                w_ff <= 1'b0;
            end
        end
    end

    // ready flags and write response
    logic wr_known;
    always_comb begin
        unique case (awaddr_ff)
            OFS_CTRL, OFS_CMD, OFS_FRAMES, OFS_DIV, OFS_BUF_ADDR, OFS_BUF_DATA, OFS_BULK:
                wr_known = 1'b1;
            default: wr_known = 1'b0;
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else begin
            o_awready <= !aw_ff && !(i_awvalid && o_awready);
            o_wready <= !w_ff && !(i_wvalid && o_wready);
            if (wr_go) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // decoded commands, one cycle
    logic cmd_wr, c_start, c_pause, c_reset, c_inc, c_cfg;
    assign cmd_wr = wr_go && awaddr_ff == OFS_CMD && wstrb_ff[0];
    assign c_start = cmd_wr && wdata_ff[CMD_START_BIT];
    assign c_pause = cmd_wr && wdata_ff[CMD_PAUSE_BIT];
    assign c_reset = cmd_wr && wdata_ff[CMD_RESET_BIT];
    assign c_inc = cmd_wr && wdata_ff[CMD_INC_BIT];
    assign c_cfg = cmd_wr && wdata_ff[CMD_CONFIG_BIT];

    // configuration registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            src_ff <= SRC_SOFT;
            cont_ff <= 1'b0;
            dual_ff <= 1'b0;
            frames_ff <= FRAMES_RESET;
            div_ff <= DIV_RESET;
            bufaddr_ff <= '0;
        end else if (wr_go) begin
            unique case (awaddr_ff)
                OFS_CTRL: begin
                    src_ff <= wdata_ff[CTRL_SRC_LSB +: 2];
                    cont_ff <= wdata_ff[CTRL_CONT_BIT];
                    dual_ff <= wdata_ff[CTRL_CH1_BIT];
                end
                OFS_FRAMES: frames_ff <= wdata_ff[11:0];
                OFS_DIV: div_ff <= wdata_ff;
                OFS_BUF_ADDR: bufaddr_ff <= wdata_ff[ADDR_W-1:0];
                default: ;
            endcase
        end
    end

    // buffer writes: single entry or bulk stream, never touch playback
    always_ff @(posedge i_clk) begin
        if (wr_go && awaddr_ff == OFS_BUF_DATA) begin
            mem[bufaddr_ff] <= wdata_ff[SAMPLE_W-1:0];
        end else if (wr_go && awaddr_ff == OFS_BULK) begin
            mem[bulk_ff] <= wdata_ff[SAMPLE_W-1:0];
        end
    end

    // bulk pointer starts at zero, rewinds on configure
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            bulk_ff <= '0;
        end else if (c_cfg) begin
            bulk_ff <= '0;
        end else if (wr_go && awaddr_ff == OFS_BULK) begin
            bulk_ff <= bulk_ff + 1'b1;
        end
    end

    // internal rate divider, one-cycle tick
    logic int_tick;
    assign int_tick = divcnt_ff == 32'h0000_0000;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            divcnt_ff <= 32'h0000_0000;
        end else if (c_cfg || int_tick) begin
            divcnt_ff <= div_ff;
        end else begin
            divcnt_ff <= divcnt_ff - 32'h0000_0001;
        end
    end

    // frame event from the selected source; counter sources also fire on the internal tick
    logic ev;
    always_comb begin
        unique case (src_ff)
            SRC_SOFT: ev = c_inc;
            SRC_EXT: ev = is_rise(ext_ff);
            SRC_CNT0: ev = is_rise(c0_ff) || int_tick;
            SRC_CNT1: ev = is_rise(c1_ff) || int_tick;
        endcase
    end

    // frame starts only when no channel 1 sample of the previous frame is pending (sec_ff low)
    logic fire;
    assign fire = ev && state_ff == ST_RUN && !sec_ff
        && !(c_reset || c_cfg || c_pause || c_start); // commands outrank events
    logic last_frame;
    logic [ADDR_W-1:0] frame_len, ptr_next;
    assign last_frame = {1'b0, frame_idx_ff} + 12'h001 >= frames_ff;
    assign frame_len = dual_ff ? 11'h002 : 11'h001;
    assign ptr_next = rptr_ff + frame_len;

    // playback state
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_ff <= ST_IDLE;
            configured_ff <= 1'b0;
            rptr_ff <= '0;
            frame_idx_ff <= '0;
        end else if (c_reset) begin
            state_ff <= ST_IDLE;
            configured_ff <= 1'b0;
            rptr_ff <= '0;
            frame_idx_ff <= '0;
        end else if (c_cfg) begin
            state_ff <= ST_IDLE;
            configured_ff <= 1'b1;
            rptr_ff <= '0;
            frame_idx_ff <= '0;
        end else if (c_pause) begin
            if (state_ff == ST_RUN) begin
                state_ff <= ST_PAUSE;
            end
        end else if (c_start) begin
            if (configured_ff && (state_ff == ST_IDLE || state_ff == ST_PAUSE)) begin
                state_ff <= ST_RUN;
            end
        end else if (fire) begin
            if (last_frame || ptr_next == '0) begin
                rptr_ff <= '0;
                frame_idx_ff <= '0;
                if (!cont_ff) begin
                    state_ff <= ST_DONE;
                end
            end else begin
                rptr_ff <= ptr_next;
                frame_idx_ff <= frame_idx_ff + 1'b1;
            end
        end
    end

    // sample sequencer: channel 0 then channel 1
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sec_ff <= 1'b0;
            emit_ff <= 1'b0;
            emit_ch_ff <= 1'b0;
            emit_addr_ff <= '0;
        end else begin
            emit_ff <= fire || sec_ff;
            if (fire) begin
                emit_addr_ff <= rptr_ff;
                emit_ch_ff <= 1'b0;
                sec_ff <= dual_ff;
            end else if (sec_ff) begin
                emit_addr_ff <= emit_addr_ff + 1'b1;
                emit_ch_ff <= 1'b1;
                sec_ff <= 1'b0;
            end
        end
    end

    // converter output registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_dac <= '0;
            o_dac_valid <= 1'b0;
        end else begin
            o_dac_valid <= emit_ff;
            if (emit_ff) begin
                o_dac.code <= mem[emit_addr_ff];
                o_dac.chan <= emit_ch_ff;
            end
        end
    end

    // read channel
    logic [31:0] rd_val;
    logic rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        unique case (i_araddr)
            OFS_CTRL: rd_val = {28'h0, dual_ff, cont_ff, src_ff};
            OFS_FRAMES: rd_val = {20'h0, frames_ff};
            OFS_DIV: rd_val = div_ff;
            OFS_STATUS: rd_val = {16'h0, frame_idx_ff, configured_ff, 2'h0, state_ff};
            OFS_BUF_ADDR: rd_val = {21'h0, bufaddr_ff};
            OFS_BUF_DATA: rd_val = {16'h0, mem[bufaddr_ff]};
            OFS_BULK: rd_val = {21'h0, bulk_ff};
            OFS_CMD: rd_val = 32'h0000_0000;
            default: begin
                rd_val = 32'h0000_0000;
                rd_ok = 1'b0;
            end
        endcase
    end
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else begin
            o_arready <= !o_rvalid && !(i_arvalid && o_arready);
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rdata <= rd_val;
                o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // checks
    chk_idle_quiet: assert property (@(posedge i_clk) disable iff (!i_rstn)
        state_ff != ST_RUN |=> rptr_ff == $past(rptr_ff) || rptr_ff == '0)
        else $error("pointer moved while not running");
    chk_oneshot_stop: assert property (@(posedge i_clk) disable iff (!i_rstn)
        fire && last_frame && !cont_ff && !c_reset && !c_cfg |=> state_ff == ST_DONE)
        else $error("one-shot did not stop");
    chk_cont_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
        fire && last_frame && cont_ff |=> rptr_ff == '0 && state_ff == ST_RUN)
        else $error("continuous did not wrap");
    chk_pause_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
        state_ff == ST_PAUSE && !c_reset && !c_cfg |=> $stable(rptr_ff))
        else $error("pointer moved in pause");
    chk_reset_clear: assert property (@(posedge i_clk) disable iff (!i_rstn)
        c_reset |=> state_ff == ST_IDLE && rptr_ff == '0 && !configured_ff)
        else $error("reset did not clear");
    chk_start_gate: assert property (@(posedge i_clk) disable iff (!i_rstn)
        !configured_ff |=> state_ff != ST_RUN) else $error("ran without config");
    chk_frame_order: assert property (@(posedge i_clk) disable iff (!i_rstn)
        fire && dual_ff |=> ##1 o_dac_valid && !o_dac.chan ##1 o_dac_valid && o_dac.chan)
        else $error("channel order wrong");
    chk_single_out: assert property (@(posedge i_clk) disable iff (!i_rstn)
        fire && !dual_ff && src_ff == SRC_SOFT |=> ##1 o_dac_valid ##1 !o_dac_valid)
        else $error("wrong sample count");
    chk_src_only: assert property (@(posedge i_clk) disable iff (!i_rstn)
        fire && src_ff == SRC_EXT |-> ext_ff[1] && !ext_ff[2]) else $error("frame without event");
endmodule
`default_nettype wire

// File: testbench/dac_waveform_generator_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dac_waveform_generator_tb_top;
    import wfg_pkg::*;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic arvalid = 1'h0;
    logic [2:0] ev = 3'h0;
    logic awready, wready, bvalid, arready, rvalid, dac_valid;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    wfg_sample_t dac;
    logic [15:0] mem [0:15];
    logic [16:0] exp_q[$];
    int err_total = 0;
    int n_compared = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    wfg_engine dut (.i_clk(clk), .i_rstn(rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
        .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid),
        .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(1'h1),
        .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata),
        .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'h1), .i_ext_clk(ev[0]),
        .i_cnt0_clk(ev[1]), .i_cnt1_clk(ev[2]), .o_dac(dac), .o_dac_valid(dac_valid));
    wfg_dac_model mdl (.i_clk(clk), .i_rstn(rstn), .i_dac(dac), .i_dac_valid(dac_valid));

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'h0;
        w_done = 1'h0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awvalid && awready === 1'h1) begin
                aw_done = 1'h1;
                awvalid <= 1'h0;
            end
            if (wvalid && wready === 1'h1) begin
                w_done = 1'h1;
                wvalid <= 1'h0;
            end
        end
        while (bvalid !== 1'h1) @(posedge clk);
        rs = bresp;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'h1;
        @(posedge clk);
        while (arready !== 1'h1) @(posedge clk);
        arvalid <= 1'h0;
        while (rvalid !== 1'h1) @(posedge clk);
        rd = rdata;
        rs = rresp;
    endtask
    task automatic cfg(input logic [31:0] c, input logic [31:0] f);
        wr(OFS_CTRL, c);
        wr(OFS_FRAMES, f);
        wr(OFS_CMD, 32'h0000_0010);
    endtask
    // clock event on the chosen source lines
    task automatic pulse(input logic [2:0] m);
        ev <= m;
        repeat (4) @(posedge clk);
        ev <= 3'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic inc();
        wr(OFS_CMD, 32'h0000_0008);
        repeat (8) @(posedge clk);
    endtask
    function automatic void ex(input int a, input logic c);
        exp_q.push_back({mem[a], c});
    endfunction
    // compare converter traffic with the expected list
    task automatic drain();
        repeat (4) @(posedge clk);
        chk("sample count", 32'(exp_q.size()), 32'(mdl.got_q.size()));
        while (exp_q.size() > 0 && mdl.got_q.size() > 0) begin
            chk("sample", {15'h0, exp_q.pop_front()}, {15'h0, mdl.got_q.pop_front()});
        end
        exp_q.delete();
        mdl.got_q.delete();
    endtask
    task automatic state(input logic [1:0] e);
        rd_reg(OFS_STATUS);
        chk("state", {30'h0, e}, {30'h0, rd[1:0]});
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'h1;
        repeat (2) @(posedge clk);
        // bulk load with junk in the upper half
        wr(OFS_CMD, 32'h0000_0010);
        wr(OFS_DIV, 32'h000F_FFFF);
        for (int i = 0; i < 16; i++) begin
            mem[i] = (i == 0) ? 16'hFFFF : 16'(i - 1) * 16'h0111;
            wr(OFS_BULK, {16'hA5C3, mem[i]});
        end
        rd_reg(OFS_BULK);
        chk("bulk pointer", 32'h10, rd);
        wr(OFS_BUF_ADDR, 32'h5);
        rd_reg(OFS_BUF_DATA);
        chk("entry 5", {16'h0, mem[5]}, {16'h0, rd[15:0]});
        $display("test load end");
        // one-shot, two channels, software increment
        cfg(32'h8, 32'h3);
        wr(OFS_CMD, 32'h1);
        for (int f = 0; f < 4; f++) begin
            inc();
            if (f < 3) begin
                ex(2 * f, 1'h0);
                ex(2 * f + 1, 1'h1);
            end
        end
        drain();
        state(2'h3);
        $display("test one-shot end");
        // continuous wrap, one channel
        cfg(32'h4, 32'h2);
        wr(OFS_CMD, 32'h1);
        repeat (3) inc();
        ex(0, 1'h0);
        ex(1, 1'h0);
        ex(0, 1'h0);
        drain();
        state(2'h1);
        $display("test continuous end");
        // each pin source: idle and foreign events ignored
        for (int s = 1; s < 4; s++) begin
            cfg(32'(s) | 32'h4, 32'h4);
            pulse(3'(1 << (s - 1)));
            wr(OFS_CMD, 32'h1);
            pulse(~3'(1 << (s - 1)));
            inc();
            ex(0, 1'h0);
            pulse(3'(1 << (s - 1)));
            drain();
        end
        $display("test sources end");
        // pause, entry write while held, resume in place
        wr(OFS_CMD, 32'h2);
        pulse(3'h4);
        wr(OFS_BUF_ADDR, 32'h1);
        wr(OFS_BUF_DATA, 32'h0000_5A5A);
        mem[1] = 16'h5A5A;
        state(2'h2);
        wr(OFS_CMD, 32'h1);
        pulse(3'h4);
        ex(1, 1'h0);
        drain();
        $display("test pause end");
        // reset command, lone start refused, buffer kept
        wr(OFS_CMD, 32'h4);
        wr(OFS_CMD, 32'h1);
        pulse(3'h4);
        state(2'h0);
        drain();
        cfg(32'h0, 32'h4);
        wr(OFS_CMD, 32'h1);
        inc();
        ex(0, 1'h0);
        drain();
        rd_reg(OFS_BUF_DATA);
        chk("entry 1", 32'h5A5A, {16'h0, rd[15:0]});
        $display("test reset end");
        // unmapped place
        rd_reg(8'h40);
        chk("read resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        chk("read data", 32'h0, rd);
        wr(8'h40, 32'h1);
        chk("write resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        $display("test unmapped end");
        end_sim();
    end
endmodule
`default_nettype wire

// File: testbench/wfg_dac_model.sv
`timescale 1ns/1ps
`default_nettype none
// converter channels: keep every sample handed over
module wfg_dac_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // samples from the engine
    input wire wfg_pkg::wfg_sample_t i_dac,
    input wire logic i_dac_valid
);
    import wfg_pkg::*;
    wfg_sample_t got_q[$];
    // code kept as delivered, in arrival order
    always @(posedge i_clk) begin
        if (i_rstn && i_dac_valid) begin
            got_q.push_back(i_dac);
        end
    end
endmodule
`default_nettype wire
